// >>> src/usfb_top.sv
/*
 * Serial frame and baud block: AXI4-Lite registers, transmitter with
 * parity and stop bits, receiver with parity check, baud prescaler,
 * synchronous clock out and one level interrupt.
 * Assumes line inputs synchronous to aclk; the sync clock is driven here.
 */
// Functional notes
// RULE1 - Parity field: 00 off, 01 reserved, 10 even, 11 odd, both ways
// RULE2 - With parity on, transmitter appends computed parity automatically
// RULE3 - With parity on, receiver checks parity and flags mismatch per character
// RULE4 - Stop select 0 sends one stop bit, 1 sends two
// RULE5 - Receiver ignores stop select; it affects only the transmitter
// RULE6 - Size code 000..011 gives 5..8 bits, 111 gives 9; others reserved
// RULE7 - Sync polarity 0: data changes rising, sampled falling; 1 reverses
// RULE8 - Software keeps polarity zero in asynchronous mode
// RULE9 - Divisor is 12 bits: four in high byte, eight in low byte
// RULE10 - Writing low byte reloads prescaler; high byte write alone does not
// RULE11 - Software changes divisor only while the line is idle
// RULE12 - High byte bits 7:4 read zero; software writes zeros there
// RULE13 - Double speed in asynchronous mode divides by 8 instead of 16
// RULE14 - Async bit period is clock period times factor times divisor plus one
`timescale 1ns/10ps
`default_nettype none

module usfb_top
    import usfb_pkg::*;
#(
    parameter int ADDR_W = 6
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Serial line
    output var  logic              tx_line,
    input  wire logic              rx_line,
    output var  logic              sync_serial_clock,
    // Interrupt
    output var  logic              irq
);

    if (ADDR_W < 6) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    function automatic logic [3:0] size_bits(input logic [2:0] code);
        unique case (code)
            3'b000:  size_bits = 4'h5;
            3'b001:  size_bits = 4'h6;
            3'b010:  size_bits = 4'h7;
            3'b111:  size_bits = 4'h9;
            default: size_bits = 4'h8; // Reserved codes run as 8 bits
        endcase
    endfunction : size_bits

    function automatic logic par_of(input logic [8:0] d,
                                    input logic [2:0] code,
                                    input logic odd);
        logic [8:0] m;
        m = 9'h1FF >> (4'h9 - size_bits(code));
        par_of = (^(d & m)) ^ odd;
    endfunction : par_of

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  baud_lo_r;
    logic [3:0]  baud_hi_r;
    usfb_cfg_t   cfg_r;
    logic        rx_en_r, tx_en_r;
    usfb_evt_t   sts_r, mask_r, evt;
    logic [8:0]  rx_data_r;
    logic        rx_full_r, par_err_r, frame_err_r;
    logic        tick;

    // AXI write side: address and data taken in either order
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    wire  do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire  [5:0] wa = {awaddr_r[5:2], 2'b00};
    wire  wr_b0  = do_wr && wstrb_r[0];
    wire  wr_lo  = wr_b0 && (wa == OFS_BAUD_LO);
    wire  wr_hi  = wr_b0 && (wa == OFS_BAUD_HI);
    wire  wr_tx  = wr_b0 && (wa == OFS_TX_DATA);
    wire  wr_hit = (wa <= OFS_IRQ_MASK) && (wa != OFS_RX_DATA);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_r      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control registers; the high byte keeps only its four live bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_lo_r <= RST_ZERO;
            baud_hi_r <= '0;
            // Field by field: a plain cast would misplace the frame bits
            cfg_r     <= '{sync: RST_FRAME[6], pmode: RST_FRAME[5:4],
                           two_stop: RST_FRAME[3],
                           size: {1'b0, RST_FRAME[2:1]},
                           pol: RST_FRAME[0], dbl: 1'b0};
            rx_en_r   <= 1'b0;
            tx_en_r   <= 1'b0;
            mask_r    <= '0;
        end else if (wr_b0) begin
            if (wa == OFS_BAUD_LO)  baud_lo_r <= wdata_r[7:0];
            if (wa == OFS_BAUD_HI)  baud_hi_r <= wdata_r[3:0]; // [RULE12]
            if (wa == OFS_FRAME) begin
                cfg_r.sync     <= wdata_r[6];
                cfg_r.pmode    <= wdata_r[5:4];                // [RULE1]
                cfg_r.two_stop <= wdata_r[3];
                cfg_r.size[1:0] <= wdata_r[2:1];
                cfg_r.pol      <= wdata_r[0];
            end
            if (wa == OFS_CTRL_A)   cfg_r.dbl <= wdata_r[BIT_DBL];
            if (wa == OFS_CTRL_B) begin
                cfg_r.size[2] <= wdata_r[BIT_SIZE_HI];          // [RULE6]
                rx_en_r       <= wdata_r[BIT_RX_EN];
                tx_en_r       <= wdata_r[BIT_TX_EN];
            end
            if (wa == OFS_IRQ_MASK) mask_r <= usfb_evt_t'(wdata_r[3:0]);
        end
    end

    // Only a low byte write reloads; a lone high byte write is taken at the next count wrap
    // The low byte lands on the reload edge, so pass the new byte through
    wire  [11:0] baud_div = {baud_hi_r, wr_lo ? wdata_r[7:0] : baud_lo_r};
    usfb_baud #(.DIV_W(12)) u_baud (
        .aclk    (aclk),
        .aresetn (aresetn),
        .divisor (baud_div),               // [RULE9]
        .reload  (wr_lo),                  // [RULE10]
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bit timing; double speed has no effect in sync mode
    wire  dbl_eff  = cfg_r.dbl && !cfg_r.sync;
    wire  [3:0] os_last = dbl_eff ? OS_LAST_DBL : OS_LAST_NORM; // [RULE13]
    wire  [3:0] os_mid  = dbl_eff ? OS_MID_DBL : OS_MID_NORM;
    wire  lead_edge = tick && (sync_serial_clock == cfg_r.pol); // [RULE7]
    wire  trail_edge = tick && (sync_serial_clock != cfg_r.pol);
    logic [3:0] tx_os_r, rx_os_r;
    wire  tx_adv = cfg_r.sync ? lead_edge : tick && (tx_os_r == os_last);
    wire  rx_smp = cfg_r.sync ? trail_edge : tick && (rx_os_r == os_mid);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_serial_clock <= 1'b0;
        end else if (cfg_r.sync && tick) begin
            sync_serial_clock <= !sync_serial_clock;
        end else if (!cfg_r.sync) begin
            sync_serial_clock <= cfg_r.pol;                     // [RULE8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    usfb_tx_t   tx_st_r;
    logic [8:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic       tx_par_r;
    wire  tx_load = wr_tx && tx_en_r && (tx_st_r == TX_IDLE);
    wire  tx_last = (tx_cnt_r == size_bits(cfg_r.size) - 4'h1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_r  <= TX_IDLE;
            tx_sh_r  <= '0;
            tx_cnt_r <= '0;
            tx_par_r <= 1'b0;
            tx_os_r  <= '0;
            tx_line  <= 1'b1;
        end else if (tx_load) begin
            tx_st_r  <= TX_START;
            tx_sh_r  <= {wdata_r[8] && wstrb_r[1], wdata_r[7:0]};
            tx_par_r <= par_of({wdata_r[8] && wstrb_r[1], wdata_r[7:0]},
                               cfg_r.size, cfg_r.pmode[0]);     // [RULE2]
            tx_os_r  <= '0;
        end else if (tx_st_r != TX_IDLE) begin
            if (tick) tx_os_r <= (tx_os_r == os_last) ? 4'h0 : tx_os_r + 4'h1;
            if (tx_adv) begin
                unique case (tx_st_r)
                    TX_START: begin
                        tx_line  <= 1'b0;
                        tx_cnt_r <= '0;
                        tx_st_r  <= TX_DATA;
                    end
                    TX_DATA: begin
                        tx_line  <= tx_sh_r[0];
                        tx_sh_r  <= {1'b0, tx_sh_r[8:1]};
                        tx_cnt_r <= tx_cnt_r + 4'h1;
                        if (tx_last)                            // [RULE6]
                            tx_st_r <= cfg_r.pmode[1] ? TX_PAR : TX_STOP1;
                    end
                    TX_PAR: begin
                        tx_line <= tx_par_r;                    // [RULE2]
                        tx_st_r <= TX_STOP1;
                    end
                    TX_STOP1: begin
                        tx_line <= 1'b1;
                        tx_st_r <= cfg_r.two_stop ? TX_STOP2 : TX_END; // [RULE4]
                    end
                    TX_STOP2: begin
                        tx_line <= 1'b1;
                        tx_st_r <= TX_END;
                    end
                    default: tx_st_r <= TX_IDLE; // End of last stop bit
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver: checks only the first stop bit
    usfb_rx_t   rx_st_r;
    logic [8:0] rx_sh_r;
    logic [3:0] rx_cnt_r;
    logic       rx_par_r;
    wire  [3:0] rx_n    = size_bits(cfg_r.size);
    wire  [8:0] rx_word = rx_sh_r >> (4'h9 - rx_n);
    wire  rx_bad_par = cfg_r.pmode[1] &&
                       (rx_par_r != par_of(rx_word, cfg_r.size, cfg_r.pmode[0]));
    wire  rx_done = rx_smp && (rx_st_r == RX_STOP);
    wire  [5:0] ra = {s_axi_araddr[5:2], 2'b00};
    wire  rd_take = s_axi_arvalid && s_axi_arready;
    wire  rd_rx   = rd_take && (ra == OFS_RX_DATA);
    wire  rd_sts  = rd_take && (ra == OFS_IRQ_STS);

    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_en_r) begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= '0;
            rx_cnt_r <= '0;
            rx_par_r <= 1'b0;
            rx_os_r <= '0;
        end else begin
            if (tick) rx_os_r <= (rx_os_r == os_last) ? 4'h0 : rx_os_r + 4'h1;
            unique case (rx_st_r)
                RX_IDLE: begin
                    rx_cnt_r <= '0;
                    if (!cfg_r.sync && !rx_line) begin
                        rx_st_r <= RX_START;
                        rx_os_r <= '0;
                    end else if (cfg_r.sync && rx_smp && !rx_line) begin
                        rx_st_r <= RX_DATA;
                    end
                end
                RX_START: if (rx_smp) rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
                RX_DATA: if (rx_smp) begin
                    rx_sh_r  <= {rx_line, rx_sh_r[8:1]};
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                    if (rx_cnt_r == rx_n - 4'h1)
                        rx_st_r <= cfg_r.pmode[1] ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (rx_smp) begin
                    rx_par_r <= rx_line;
                    rx_st_r  <= RX_STOP;
                end
                default: if (rx_smp) rx_st_r <= RX_IDLE; // [RULE5]
            endcase
        end
    end

    // Flags belong to the character in the data register
    always_ff @(posedge aclk) begin
        if (!aresetn || !rx_en_r) begin
            rx_data_r   <= '0;
            rx_full_r   <= 1'b0;
            par_err_r   <= 1'b0;
            frame_err_r <= 1'b0;
        end else if (rx_done) begin
            rx_data_r   <= rx_word;
            rx_full_r   <= 1'b1;
            par_err_r   <= rx_bad_par;                          // [RULE3]
            frame_err_r <= !rx_line;
        end else if (rd_rx) begin
            rx_full_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: new events beat a clearing read
    assign evt.rx_done   = rx_done;
    assign evt.tx_done   = tx_adv && (tx_st_r == TX_END);
    assign evt.par_err   = rx_done && rx_bad_par;               // [RULE3]
    assign evt.frame_err = rx_done && !rx_line;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sts_r <= '0;
            irq   <= 1'b0;
        end else begin
            sts_r <= (rd_sts ? usfb_evt_t'(4'h0) : sts_r) | evt;
            irq   <= |(sts_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read side; one cycle from address to data
    wire [7:0] ctrl_a = {rx_full_r, 1'b0, tx_st_r == TX_IDLE, frame_err_r,
                         1'b0, par_err_r, cfg_r.dbl, 1'b0};
    wire [7:0] ctrl_b = {3'h0, rx_en_r, tx_en_r, cfg_r.size[2], 2'h0};
    wire [7:0] frame  = {1'b0, cfg_r.sync, cfg_r.pmode, cfg_r.two_stop,
                         cfg_r.size[1:0], cfg_r.pol};
    wire rd_hit = (ra <= OFS_IRQ_MASK) && (ra != OFS_TX_DATA);
    logic [31:0] rmux;

    always_comb begin
        unique case (ra)
            OFS_CTRL_A:   rmux = {24'h0, ctrl_a};
            OFS_CTRL_B:   rmux = {24'h0, ctrl_b};
            OFS_FRAME:    rmux = {24'h0, frame};
            OFS_BAUD_LO:  rmux = {24'h0, baud_lo_r};
            OFS_BAUD_HI:  rmux = {28'h0, baud_hi_r};            // [RULE12]
            OFS_RX_DATA:  rmux = {23'h0, rx_data_r};
            OFS_IRQ_STS:  rmux = {28'h0, sts_r};
            OFS_IRQ_MASK: rmux = {28'h0, mask_r};
            default:      rmux = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rmux;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    par_bit_a: assert property ( // [RULE2]
        @(posedge aclk) disable iff (!aresetn)
        (tx_st_r == TX_PAR && tx_adv) |=> tx_line == $past(tx_par_r))
        else $error("parity bit not sent");
    par_off_a: assert property ( // [RULE1]
        @(posedge aclk) disable iff (!aresetn)
        (tx_st_r == TX_DATA && tx_adv && tx_last && !cfg_r.pmode[1])
        |=> tx_st_r == TX_STOP1)
        else $error("parity sent while disabled");
    par_flag_a: assert property ( // [RULE3]
        @(posedge aclk) disable iff (!aresetn)
        rx_done |=> par_err_r == $past(rx_bad_par) && sts_r.rx_done)
        else $error("parity error flag wrong");
    stop_two_a: assert property ( // [RULE4]
        @(posedge aclk) disable iff (!aresetn)
        (tx_st_r == TX_STOP1 && tx_adv)
        |=> tx_st_r == ($past(cfg_r.two_stop) ? TX_STOP2 : TX_END))
        else $error("stop bit count wrong");
    size_cnt_a: assert property ( // [RULE6]
        @(posedge aclk) disable iff (!aresetn)
        (tx_st_r == TX_DATA) |-> tx_cnt_r < size_bits(cfg_r.size))
        else $error("too many data bits");
    sync_edge_a: assert property ( // [RULE7]
        @(posedge aclk) disable iff (!aresetn)
        (cfg_r.sync && tx_st_r != TX_IDLE && $changed(tx_line)
         && $stable(cfg_r)) |-> sync_serial_clock != cfg_r.pol)
        else $error("data changed on sampling edge");
    hi_zero_a: assert property ( // [RULE12]
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && ra == OFS_BAUD_HI) |=> s_axi_rdata[31:4] == 28'h0)
        else $error("reserved baud bits read nonzero");
    irq_level_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (|(sts_r & mask_r)) |=> irq)
        else $error("interrupt not raised");
    dbl_span_a: assert property ( // [RULE13]
        @(posedge aclk) disable iff (!aresetn)
        (!cfg_r.sync && cfg_r.dbl && tx_st_r != TX_IDLE) |-> tx_os_r <= 4'h7)
        else $error("double speed divider wrong");

endmodule : usfb_top

`default_nettype wire

// >>> src/usfb_pkg.sv
/*
 * Package of the serial frame and baud block: register offsets, field
 * positions, reset values and frame types.
 * Assumes a 32-bit AXI4-Lite register bus, each register one aligned word.
 */
package usfb_pkg;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL_A    = 6'h00;
    localparam logic [5:0] OFS_CTRL_B    = 6'h04;
    localparam logic [5:0] OFS_FRAME     = 6'h08;
    localparam logic [5:0] OFS_BAUD_LO   = 6'h0C;
    localparam logic [5:0] OFS_BAUD_HI   = 6'h10;
    localparam logic [5:0] OFS_TX_DATA   = 6'h14;
    localparam logic [5:0] OFS_RX_DATA   = 6'h18;
    localparam logic [5:0] OFS_IRQ_STS   = 6'h1C;
    localparam logic [5:0] OFS_IRQ_MASK  = 6'h20;

    // Field positions
    localparam int BIT_RX_FULL   = 7;
    localparam int BIT_TX_IDLE   = 5;
    localparam int BIT_FRAME_ERR = 4;
    localparam int BIT_PAR_ERR   = 2;
    localparam int BIT_DBL       = 1;
    localparam int BIT_RX_EN     = 4;
    localparam int BIT_TX_EN     = 3;
    localparam int BIT_SIZE_HI   = 2;

    // Reset values
    localparam logic [7:0] RST_FRAME  = 8'h06;
    localparam logic [7:0] RST_ZERO   = 8'h00;

    // Oversampling: last count and mid-bit count per speed
    localparam logic [3:0] OS_LAST_NORM = 4'hF;
    localparam logic [3:0] OS_LAST_DBL  = 4'h7;
    localparam logic [3:0] OS_MID_NORM  = 4'h7;
    localparam logic [3:0] OS_MID_DBL   = 4'h3;

    // Parity mode codes
    localparam logic [1:0] PAR_OFF  = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD  = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Frame configuration as software set it
    typedef struct packed {
        logic       sync;
        logic [1:0] pmode;
        logic       two_stop;
        logic [2:0] size;
        logic       pol;
        logic       dbl;
    } usfb_cfg_t;

    // Interrupt events, also the layout of status and mask
    typedef struct packed {
        logic frame_err;
        logic par_err;
        logic tx_done;
        logic rx_done;
    } usfb_evt_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP1 = 3'b100,
        TX_STOP2 = 3'b101,
        TX_END   = 3'b110
    } usfb_tx_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_PAR   = 3'b011,
        RX_STOP  = 3'b100
    } usfb_rx_t;

endpackage : usfb_pkg

// >>> src/usfb_baud.sv
/*
 * Baud prescaler: a down counter that pulses once every divisor+1 clocks.
 * Assumes the divisor is stable except when reload is pulsed.
 */
`timescale 1ns/10ps
`default_nettype none

module usfb_baud
    import usfb_pkg::*;
#(
    parameter int DIV_W = 12
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Divisor control
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic             reload,
    // Prescaled tick
    output var  logic             tick
);

    logic [DIV_W-1:0] cnt_r;
    wire              cnt_zero = (cnt_r == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (reload) begin
            cnt_r <= divisor;                           // [RULE10]
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_zero ? divisor : cnt_r - 1'b1; // [RULE14]
            tick  <= cnt_zero;
        end
    end

    reload_take_a: assert property ( // [RULE10]
        @(posedge aclk) disable iff (!aresetn)
        reload |=> (cnt_r == $past(divisor)) && !tick)
        else $error("prescaler did not reload");

endmodule : usfb_baud

`default_nettype wire

// >>> verification/usfb_line_model.sv
/* Line partner: drives frames onto rx_line, captures frames off tx_line.
 * Assumes async frames; the caller gives the bit period in aclk cycles. */
`timescale 1ns/10ps
`default_nettype none
module usfb_line_model (
    // Clock
    input  wire logic aclk,
    // Serial line
    input  wire logic tx_line,
    output var  logic rx_line
);
    initial rx_line = 1'h1;
    ////////////////////////////////////////////////////////////////////////
    // Stop bits only as the caller puts them in b, whatever the stop select says
    task send(input logic [15:0] b, input int n, input int per);
        for (int k = 0; k < n; k++) begin
            rx_line <= b[k];
            repeat (per) @(posedge aclk);
        end
        rx_line <= 1'h1;
    endtask : send
    // Mid-bit sampling; returns in mid of the last bit
    task grab(input int n, input int per, output logic [15:0] g);
        int i;
        g = '1;
        for (i = 0; i < 5000 && tx_line; i++) @(negedge aclk);
        if (i == 5000) usfb_top_tb.finish_test(1);
        repeat (per / 2) @(negedge aclk);
        for (int k = 0; k < n; k++) begin
            g[k] = tx_line;
            if (k < n - 1) repeat (per) @(negedge aclk);
        end
    endtask : grab
endmodule : usfb_line_model
`default_nettype wire

// >>> verification/usfb_top_tb.sv
/* Bench: AXI4-Lite tasks, frame table, receive and interrupt checks.
 * Assumes usfb_top and usfb_line_model; 40 ns clock. */
`timescale 1ns/10ps
`default_nettype none
module usfb_top_tb;
    import usfb_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [5:0]  aw = '0, ar = '0;
    logic [31:0] wd = '0, rv, rdata;
    logic        awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic        awrdy, wrdy, bvld, arrdy, rvld, tx_line, rx_line, sck, irq;
    logic [1:0]  bresp, rresp, rsp;
    logic [15:0] g;
    int          n_mismatch = 0, n_checks = 0, per, len;
    logic [1:0]  pm [3] = '{PAR_EVEN, PAR_ODD, PAR_OFF};
    logic [2:0]  sz [3] = '{3'h3, 3'h0, 3'h7};
    logic [8:0]  dt [3] = '{9'h035, 9'h012, 9'h1A5};
    logic [7:0]  dv [3] = '{8'h00, 8'h01, 8'h01};
    logic        s2 [3] = '{1'h1, 1'h0, 1'h0};
    logic        db [3] = '{1'h0, 1'h1, 1'h0};
    int          nb [3] = '{8, 5, 9};
    initial forever #20 aclk = ~aclk;
    usfb_top i_usfb_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvld),
        .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvld), .s_axi_rready(rry), .tx_line(tx_line),
        .rx_line(rx_line), .sync_serial_clock(sck), .irq(irq));
    usfb_line_model i_usfb_line_model (.aclk(aclk), .tx_line(tx_line),
        .rx_line(rx_line));
    ////////////////////////////////////////////////////////////////////////
    task finish_test(input int bad);
        n_mismatch += bad;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Handshakes judged mid-cycle, released after the taking edge
    task wr(input logic [5:0] a, input logic [31:0] d);
        int   i;
        logic ha, hw, hb;
        @(posedge aclk);
        aw <= a; wd <= d; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ha = awv & awrdy; hw = wv & wrdy; hb = bry & bvld; rsp = bresp;
            @(posedge aclk);
            if (ha) awv <= 1'h0;
            if (hw) wv <= 1'h0;
            if (hb) break;
        end
        bry <= 1'h0;
        if (i == 50) finish_test(1);
    endtask : wr
    task rdreg(input logic [5:0] a, output logic [31:0] d);
        int   i;
        logic ha, hr;
        @(posedge aclk);
        ar <= a; arv <= 1'h1; rry <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ha = arv & arrdy; hr = rry & rvld; d = rdata; rsp = rresp;
            @(posedge aclk);
            if (ha) arv <= 1'h0;
            if (hr) break;
        end
        rry <= 1'h0;
        if (i == 50) finish_test(1);
    endtask : rdreg
    task rdchk(input logic [5:0] a, input logic [31:0] exp);
        rdreg(a, rv);
        chk(rv, exp);
    endtask : rdchk
    function automatic logic [15:0] frm(int n, logic [1:0] p, logic [8:0] d);
        logic [15:0] f;
        f = '1;
        f[0] = 1'h0;
        for (int k = 0; k < n; k++) f[k+1] = d[k];
        if (p[1]) f[n+1] = ^(d & (9'h1FF >> (9 - n))) ^ p[0];
        return f;
    endfunction : frm
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        rdchk(OFS_FRAME, 32'h06);
        rdchk(OFS_BAUD_LO, 32'h0);
        wr(OFS_BAUD_HI, 32'hFF);
        rdchk(OFS_BAUD_HI, 32'h0F);
        wr(OFS_BAUD_HI, 32'h00);
        rdreg(6'h24, rv);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        chk({31'h0, sck}, 32'h0);
        $display("test regs done");
        for (int t = 0; t < 3; t++) begin
            wr(OFS_FRAME, {26'h0, pm[t], s2[t], sz[t][1:0], 1'h0});
            wr(OFS_CTRL_B, {28'h0, 1'h1, sz[t][2], 2'h0});
            wr(OFS_CTRL_A, {30'h0, db[t], 1'h0});
            wr(OFS_BAUD_LO, {24'h0, dv[t]});
            rdreg(OFS_IRQ_STS, rv);
            wr(OFS_TX_DATA, {23'h0, dt[t]});
            per = (db[t] ? 8 : 16) * (dv[t] + 1);
            len = 2 + nb[t] + pm[t][1] + s2[t];
            i_usfb_line_model.grab(len, per, g);
            chk({16'h0, g}, {16'h0, frm(nb[t], pm[t], dt[t])});
            rdchk(OFS_IRQ_STS, 32'h0);
            repeat (per) @(posedge aclk);
            rdchk(OFS_IRQ_STS, 32'h2);
            $display("test frame %0d done", t);
        end
        wr(OFS_FRAME, 32'h46);
        wr(OFS_TX_DATA, 32'h5A);
        @(negedge aclk);
        rv = {31'h0, !sck};
        repeat (2) @(negedge aclk);
        chk({31'h0, sck}, rv);
        repeat (64) @(posedge aclk);
        $display("test sync done");
        wr(OFS_FRAME, 32'h2E);
        wr(OFS_CTRL_B, 32'h18);
        wr(OFS_BAUD_LO, 32'h00);
        wr(OFS_IRQ_MASK, 32'h5);
        rdreg(OFS_IRQ_STS, rv);
        i_usfb_line_model.send({6'h3F, 1'h1, 8'h35, 1'h0}, 11, 16);
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rdchk(OFS_IRQ_STS, 32'h5);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0);
        rdchk(OFS_CTRL_A, 32'hA4);
        rdchk(OFS_RX_DATA, 32'h35);
        $display("test receive done");
        finish_test(0);
    end
endmodule : usfb_top_tb
`default_nettype wire
